// file: cbo_pkg.sv
// Package: types, field layouts and timing constants of the counter sequencer
`default_nettype none

package cbo_pkg;

  // ==========================================================================
  // Modes and carriers
  typedef enum logic [2:0] {
    MODE_FREQ,
    MODE_PERIOD,
    MODE_RATIO,
    MODE_INTERVAL,
    MODE_UNIT,
    MODE_OSC
  } cbo_mode_t;

  typedef struct packed {
    cbo_mode_t  mode;
    logic [1:0] range;
    logic       ext_en;
    logic       mhz1;
  } cbo_cfg_t;

  // Digit fields: digit k (1..8) sits at bits 4k-1 .. 4k-4
  typedef struct packed {
    logic        ovf;
    logic [3:0]  dp_pos;
    logic [31:0] digits;
  } cbo_meas_t;

  // ==========================================================================
  // Counts and positions
  localparam int         NUM_DIGITS  = 8;
  localparam int         FIFO_DEPTH  = 8;
  localparam logic [3:0] DP_NONE     = 4'h0;
  localparam logic [3:0] BCD_MAX     = 4'h9;
  localparam logic [2:0] DIG_MSD     = 3'h7;
  localparam logic [9:0] RANGE_COUNT [4] = '{10'h001, 10'h00A, 10'h064,
                                              10'h3E8};

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int REF_DIV_10M   = 100000;
  localparam int REF_DIV_1M    = 10000;
  localparam int MUX_DIV_10M   = 2 * 10000;
  localparam int MUX_DIV_1M    = 2 * 1000;
  localparam int IDLE_10M      = 2 * 1000000;
  localparam int IDLE_1M       = 2 * 100000;
  localparam int IA_UPDATE_MS  = 200;
  localparam int BCD_LEAD_NS   = 4000;
  localparam int LAG_MIN_NS    = 2000;
  localparam int LAG_MAX_NS    = 6000;
  localparam int BCD_LEAD_CYC  = (BCD_LEAD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int LAG_MIN_CYC   = (LAG_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int LAG_MAX_CYC   = LAG_MAX_NS / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// file: cbo_top.sv
// Counter sequencing, result FIFO and multiplexed BCD digit scan
`default_nettype none

// Overview of operation
// [RULE_01] Clear input low clears counter, aborts measurement, shows all zeros.
// [RULE_02] External gate enabled sets measurement duration in every mode; unit mode here never leaves S_ARM and ignores it.
// [RULE_03] External gate sampled on each 100Hz reference tick to start or stop.
// [RULE_04] Short arbitrary gates belong on input B in ratio mode, not here.
// [RULE_05] Measuring output is low during measurement, high between them.
// [RULE_06] Digit value shown while its drive is on; scan runs digit 8 to 1.
// [RULE_07] BCD data changes first; digit drive follows 2 to 6 us later.
// [RULE_08] Outside logic latches BCD data on the digit drive starting edge.
// [RULE_09] BCD outputs carry true digits, zeros included, never blanked.
// [RULE_10] Digits are plain 8-4-2-1 binary, weight 8 as top bit.
// [RULE_11] Decimal point placed by mode and range; none for external gate.
// [RULE_12] Any overflow lights the decimal point of digit 8.
// [RULE_13] Single interval: outside primes with A fall then B fall.
// [RULE_14] After priming on the one-cycle range, exactly one A-to-B event.
// [RULE_15] Repetitive interval signals prime the logic by themselves.
// [RULE_16] Interval mode waits 200 ms after B falls before a new cycle.
// [RULE_17] Scan rate is oscillator over 2x10^4, or 2x10^3 in 1 MHz mode.
// [RULE_18] Idle gap is 2x10^6 oscillator periods, or 2x10^5 in 1 MHz mode.
// [RULE_19] Buffered oscillator copy is driven on its own output.
// [RULE_20] 100Hz reference divides the timebase by 10^5, or 10^4 at 1 MHz.
// [RULE_21] Between measurements, store strobe pulses, then clear strobe.
// [RULE_22] Clear input is a level reset; fresh measurement after release.

// ============================================================================
// Result FIFO
module cbo_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  localparam logic [AW-1:0] LAST = (AW)'(D - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign o_in_ready  = cnt_reg != FULL;
  assign o_out_valid = cnt_reg != '0;
  assign o_out_data  = mem[rd_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule // cbo_fifo

// ============================================================================
// Top
module cbo_top #(
  parameter int P_REF_DIV_10M   = cbo_pkg::REF_DIV_10M,
  parameter int P_REF_DIV_1M    = cbo_pkg::REF_DIV_1M,
  parameter int P_MUX_DIV_10M   = cbo_pkg::MUX_DIV_10M,
  parameter int P_IDLE_10M      = cbo_pkg::IDLE_10M,
  parameter int P_IDLE_1M       = cbo_pkg::IDLE_1M,
  parameter int P_IA_UPDATE_CYC = cbo_pkg::IA_UPDATE_MS * 1000000
                                  / cbo_pkg::CLK_PERIOD_NS
) (
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  input  wire logic              i_clear_n,
  input  wire logic              i_external_gate_in,
  input  wire logic              i_in_a,
  input  wire logic              i_in_b,
  input  wire logic              i_osc_in,
  input  wire cbo_pkg::cbo_cfg_t i_cfg,
  output logic [3:0]             o_bcd,
  output logic [7:0]             o_digit,
  output logic                   o_dp,
  output logic                   o_measuring_n,
  output logic                   o_store_strobe,
  output logic                   o_clear_strobe,
  output logic                   o_buf_osc
);
  localparam int MW = $bits(cbo_pkg::cbo_meas_t);
  localparam logic [15:0] LEAD = 16'(cbo_pkg::BCD_LEAD_CYC);

  typedef enum logic [2:0] {S_ARM, S_GATE, S_STORE, S_CLRP, S_GAP}
    cbo_state_t;

  function automatic logic [32:0] bcd_inc(input logic [31:0] d);
    logic [32:0] r;
    logic        c;
    r = '0;
    c = 1'b1;
    for (int i = 0; i < cbo_pkg::NUM_DIGITS; i++) begin
      if (c && d[i*4 +: 4] == cbo_pkg::BCD_MAX) begin
        r[i*4 +: 4] = 4'h0;
      end else begin
        r[i*4 +: 4] = d[i*4 +: 4] + {3'h0, c};
        c = 1'b0;
      end
    end
    r[32] = c;
    return r;
  endfunction

  function automatic logic [3:0] dp_position(input cbo_pkg::cbo_cfg_t c);
    logic [3:0] p;
    p = {2'h0, c.range} + 4'h2;
    if (c.ext_en) begin
      p = cbo_pkg::DP_NONE;
    end else if (c.mode == cbo_pkg::MODE_UNIT) begin
      p = 4'h1;
    end else if (c.mode == cbo_pkg::MODE_RATIO) begin
      p = {2'h0, c.range} + 4'h1;
    end else if (c.mhz1 && (c.mode == cbo_pkg::MODE_PERIOD ||
                            c.mode == cbo_pkg::MODE_INTERVAL)) begin
      p = p - 4'h1;
    end
    return p;
  endfunction

  // ==========================================================================
  // Pin synchronisers and edges
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] prev_reg;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg  <= '0;
    end else begin
      sync1_reg <= {i_osc_in, i_clear_n, i_external_gate_in, i_in_b, i_in_a};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic a_rise, a_fall, b_rise, b_fall, ext_lvl, clear_act, osc_tick;
  logic rst_all, is_unit;
  assign a_rise    = sync2_reg[0] && !prev_reg[0];
  assign a_fall    = !sync2_reg[0] && prev_reg[0];
  assign b_rise    = sync2_reg[1] && !prev_reg[1];
  assign b_fall    = !sync2_reg[1] && prev_reg[1];
  assign ext_lvl   = sync2_reg[2];
  assign clear_act = !sync2_reg[3];
  assign osc_tick  = sync2_reg[4] && !prev_reg[4];
  assign rst_all   = i_srst || clear_act; // RULE_01 RULE_22
  assign is_unit   = i_cfg.mode == cbo_pkg::MODE_UNIT;

  always_ff @(posedge i_clk) begin
    o_buf_osc <= i_srst ? 1'b0 : sync2_reg[4]; // RULE_19
  end

  // ==========================================================================
  // 100Hz reference
  logic [31:0] ref_cnt_reg;
  logic        ref_last;
  logic        ref_tick;
  // Compare with >= so a mode change mid-count cannot skip the limit and wrap
  assign ref_last = ref_cnt_reg >= (i_cfg.mhz1 ? 32'(P_REF_DIV_1M - 1)
                                               : 32'(P_REF_DIV_10M - 1));
  assign ref_tick = osc_tick && ref_last;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ref_cnt_reg <= '0;
    end else if (osc_tick) begin
      ref_cnt_reg <= ref_last ? '0 : ref_cnt_reg + 32'h1; // RULE_20
    end
  end

  // ==========================================================================
  // Gate events per mode
  cbo_state_t  state_reg;
  logic        primed_reg, prime_a_reg, ia_run_reg;
  logic        src_evt, start_evt, gate_evt, done, range_chg, cnt_clr;
  logic [1:0]  range_prev_reg;
  logic [9:0]  gcnt_reg;
  logic [31:0] gap_reg;
  logic        gap_step, gap_last;
  logic        fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [MW-1:0] fifo_out;

  always_comb begin
    src_evt   = osc_tick;
    start_evt = 1'b0;
    gate_evt  = 1'b0;
    unique case (i_cfg.mode)
      cbo_pkg::MODE_FREQ, cbo_pkg::MODE_OSC: begin
        src_evt   = (i_cfg.mode == cbo_pkg::MODE_FREQ) ? a_rise : osc_tick;
        start_evt = ref_tick;
        gate_evt  = ref_tick;
      end
      cbo_pkg::MODE_PERIOD: begin
        start_evt = a_rise;
        gate_evt  = a_rise;
      end
      cbo_pkg::MODE_RATIO: begin
        src_evt   = a_rise;
        start_evt = b_rise;
        gate_evt  = b_rise;
      end
      cbo_pkg::MODE_INTERVAL: begin
        src_evt   = osc_tick && ia_run_reg;
        start_evt = a_fall && primed_reg;                  // RULE_14
        gate_evt  = b_fall && ia_run_reg;
      end
      cbo_pkg::MODE_UNIT: src_evt = a_rise;
      default: src_evt = 1'b0;
    endcase
    if (i_cfg.ext_en) begin
      start_evt = ref_tick && ext_lvl;                     // RULE_02 RULE_03
    end
  end

  assign done = i_cfg.ext_en ? (ref_tick && !ext_lvl)     // RULE_03
              : (gate_evt && gcnt_reg == cbo_pkg::RANGE_COUNT[i_cfg.range]
                 - 10'h001);
  // A range change discards the reading under way, except in unit mode
  assign range_chg = !is_unit && i_cfg.range != range_prev_reg &&
                     (state_reg == S_ARM || state_reg == S_GATE);
  assign cnt_clr   = state_reg == S_CLRP || range_chg;
  assign gap_step  = (i_cfg.mode == cbo_pkg::MODE_INTERVAL) || osc_tick;
  assign gap_last  = gap_step && gap_reg >= (
      (i_cfg.mode == cbo_pkg::MODE_INTERVAL) ? 32'(P_IA_UPDATE_CYC - 1)
      : i_cfg.mhz1 ? 32'(P_IDLE_1M - 1) : 32'(P_IDLE_10M - 1));

  // ==========================================================================
  // Interval priming
  always_ff @(posedge i_clk) begin
    if (rst_all || cnt_clr) begin
      prime_a_reg <= 1'b0;
      primed_reg  <= 1'b0;
      ia_run_reg  <= 1'b0;
    end else begin
      if (a_fall) begin
        prime_a_reg <= 1'b1;
      end
      if (b_fall && prime_a_reg) begin
        primed_reg <= 1'b1;                                // RULE_13 RULE_15
      end
      if (b_fall) begin
        ia_run_reg <= 1'b0;
      end
      if (a_fall && (state_reg == S_GATE ||
                     (state_reg == S_ARM && start_evt))) begin
        ia_run_reg <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      state_reg <= S_ARM;                                  // RULE_22
      gcnt_reg  <= '0;
      gap_reg   <= '0;
    end else begin
      unique case (state_reg)
        S_ARM: begin
          gcnt_reg <= '0;
          if (!is_unit && !range_chg && start_evt) begin
            state_reg <= S_GATE;
          end
        end
        S_GATE: begin
          if (range_chg) begin
            state_reg <= S_ARM;
          end else if (done) begin
            state_reg <= S_STORE;                          // RULE_14
          end else if (gate_evt) begin
            gcnt_reg <= gcnt_reg + 10'h001;
          end
        end
        S_STORE: begin
          // Stalls here while the result FIFO is full
          if (fifo_in_ready) begin
            state_reg <= S_CLRP;                           // RULE_21
          end
        end
        S_CLRP: begin
          state_reg <= S_GAP;
          gap_reg   <= '0;
        end
        S_GAP: begin
          if (gap_last) begin
            state_reg <= S_ARM;                            // RULE_16 RULE_18
          end else if (gap_step) begin
            gap_reg <= gap_reg + 32'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    range_prev_reg <= i_srst ? 2'h0 : i_cfg.range;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_measuring_n  <= 1'b1;
      o_store_strobe <= 1'b0;
      o_clear_strobe <= 1'b0;
    end else begin
      o_measuring_n  <= !(state_reg == S_ARM || state_reg == S_GATE); // RULE_05
      o_store_strobe <= state_reg == S_STORE && fifo_in_ready;        // RULE_21
      o_clear_strobe <= state_reg == S_CLRP;                          // RULE_21
    end
  end

  // ==========================================================================
  // Main counter
  logic [31:0] cnt_reg;
  logic        ovf_reg;
  logic [32:0] cnt_inc;
  assign cnt_inc = bcd_inc(cnt_reg);                       // RULE_10

  always_ff @(posedge i_clk) begin
    if (rst_all || cnt_clr) begin
      cnt_reg <= '0;                                       // RULE_01
      ovf_reg <= 1'b0;
    end else if (src_evt && (is_unit || state_reg == S_GATE)) begin
      cnt_reg <= cnt_inc[31:0];
      if (cnt_inc[32]) begin
        ovf_reg <= 1'b1;                                   // RULE_12
      end
    end
  end

  // ==========================================================================
  // Result FIFO and display latch
  cbo_pkg::cbo_meas_t disp_reg;
  cbo_pkg::cbo_meas_t live;
  logic [2:0]  dig_reg;
  logic [31:0] slot_cnt_reg;
  logic        slot_tick, scan_start, load_reg;
  logic [15:0] lag_reg;

  assign live       = '{ovf: ovf_reg, dp_pos: dp_position(i_cfg),
                        digits: cnt_reg};
  assign scan_start = slot_tick && dig_reg == 3'h0;
  assign fifo_pop   = scan_start && !is_unit;

  cbo_fifo #(
    .W (MW),
    .D (cbo_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_srst      (rst_all),
    .i_in_valid  (state_reg == S_STORE),
    .i_in_data   (live),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out),
    .i_out_ready (fifo_pop)
  );

  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      disp_reg <= '0;                                      // RULE_01
    end else if (scan_start) begin
      if (is_unit) begin
        disp_reg <= live;
      end else if (fifo_out_valid) begin
        disp_reg <= cbo_pkg::cbo_meas_t'(fifo_out);
      end
    end
  end

  // ==========================================================================
  // Digit scan; slot must outlast the BCD lead time
  assign slot_tick = osc_tick && slot_cnt_reg >= (i_cfg.mhz1
      ? 32'(cbo_pkg::MUX_DIV_1M / cbo_pkg::NUM_DIGITS - 1)
      : 32'(P_MUX_DIV_10M / cbo_pkg::NUM_DIGITS - 1));     // RULE_17

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      slot_cnt_reg <= '0;
      dig_reg      <= 3'h0;
      load_reg     <= 1'b0;
      lag_reg      <= LEAD;
      o_bcd        <= 4'h0;
      o_digit      <= 8'h00;
      o_dp         <= 1'b0;
    end else begin
      if (osc_tick) begin
        slot_cnt_reg <= slot_tick ? '0 : slot_cnt_reg + 32'h1;
      end
      if (slot_tick) begin
        dig_reg  <= dig_reg - 3'h1;                        // RULE_06
        load_reg <= 1'b1;
        o_digit  <= 8'h00;
        o_dp     <= 1'b0;
      end else if (load_reg) begin
        load_reg <= 1'b0;
        lag_reg  <= '0;
        o_bcd    <= disp_reg.digits[dig_reg*4 +: 4];       // RULE_09 RULE_07
      end else if (lag_reg != LEAD) begin
        lag_reg <= lag_reg + 16'h1;
        if (lag_reg == LEAD - 16'h1) begin
          o_digit <= 8'h01 << dig_reg;                     // RULE_06 RULE_07
          o_dp    <= (disp_reg.dp_pos != cbo_pkg::DP_NONE &&
                      {1'b0, dig_reg} == disp_reg.dp_pos - 4'h1) || // RULE_11
                     (dig_reg == cbo_pkg::DIG_MSD && disp_reg.ovf); // RULE_12
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  logic [15:0] age_reg;
  always_ff @(posedge i_clk) begin
    if (i_srst || load_reg) begin
      age_reg <= '0;
    end else if (age_reg != 16'hFFFF) begin
      age_reg <= age_reg + 16'h1;
    end
  end

  a_clear_zeroes: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_01
    clear_act |=> (disp_reg.digits == '0 && state_reg == S_ARM))
    else $error("clear did not zero display and abort");
  a_ext_stop_tick: assert property (@(posedge i_clk) disable iff (rst_all) // RULE_03
    (i_cfg.ext_en && state_reg == S_GATE) ##1 (state_reg == S_STORE)
    |-> $past(ref_tick))
    else $error("external gate stop off reference tick");
  a_meas_level: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_05
    (state_reg == S_GATE) |=> !o_measuring_n)
    else $error("measuring output high during measurement");
  a_scan_order: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_06
    (slot_tick && dig_reg == 3'h7) |=> dig_reg == 3'h6 ##0 load_reg)
    else $error("digit scan order wrong");
  a_bcd_lead: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_07
    $rose(|o_digit) |-> (age_reg >= 16'(cbo_pkg::LAG_MIN_CYC) &&
                         age_reg <= 16'(cbo_pkg::LAG_MAX_CYC)))
    else $error("digit drive lag outside window");
  a_bcd_range: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_10
    (|o_digit) |-> o_bcd <= cbo_pkg::BCD_MAX)
    else $error("BCD value above nine");
  a_ovf_point: assert property (@(posedge i_clk) disable iff (i_srst) // RULE_12
    (o_digit[7] && disp_reg.ovf) |-> o_dp)
    else $error("overflow point not lit on top digit");
  a_store_clear: assert property (@(posedge i_clk) disable iff (rst_all) // RULE_21
    o_store_strobe |=> (o_clear_strobe && o_measuring_n))
    else $error("clear strobe did not follow store strobe");
endmodule // cbo_top

`default_nettype wire

// file: cbo_far_end.sv
// Far-side model: free-running timebase and BCD latch logic
`default_nettype none

module cbo_far_end (
  input  wire logic       i_clk,
  input  wire logic [3:0] i_bcd,
  input  wire logic [7:0] i_digit,
  input  wire logic       i_dp,
  output logic            o_osc,
  output logic [31:0]     o_vals,
  output logic [7:0]      o_dp_mask,
  output int              o_order_err,
  output int              o_bad,
  output int              o_lag,
  output int              o_slot
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] bcd_q = 4'h0;
  logic [7:0] dig_q = 8'h00;
  int         since = 0;
  int         gap   = 0;
  int         last  = 0;

  // ==========================================================================
  // Timebase
  // Offset by 1 ns so that no osc edge meets a clock edge
  initial begin
    o_osc = 1'b0;
    #1;
    forever #10 o_osc = ~o_osc;
  end

  // ==========================================================================
  // Latch on the starting edge of each digit drive
  always @(posedge i_clk) begin
    bcd_q <= i_bcd;
    dig_q <= i_digit;
    gap   <= gap + 1;
    if (i_bcd !== bcd_q || (i_digit == 8'h00 && dig_q != 8'h00))
      since <= 0;
    else
      since <= since + 1;
    if (i_digit != 8'h00 && i_bcd !== bcd_q)
      o_bad <= o_bad + 1;
    if (i_digit != 8'h00 && i_bcd > 4'h9)
      o_bad <= o_bad + 1;
    if (i_digit != 8'h00 && dig_q == 8'h00) begin
      o_lag  <= since;
      o_slot <= gap;
      gap    <= 0;
      for (int k = 0; k < 8; k++) begin
        if (i_digit[k]) begin
          o_vals[4*k+3 -: 4] <= i_bcd;
          o_dp_mask[k]       <= i_dp;
          if (k != (last + 7) % 8)
            o_order_err <= o_order_err + 1;
          last = k;
        end
      end
    end
  end
endmodule // cbo_far_end

`default_nettype wire

// file: counter_sequencing_and_bcd_output_bench.sv
// Testbench: sequencing, strobes, gating and BCD scan of the counter
`default_nettype none

module counter_sequencing_and_bcd_output_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int RDIV = 20;
  localparam int MUX  = 1920;
  localparam int ID10 = 50;
  localparam int ID1  = 20;
  localparam int IAU  = 100;

  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic clear_n = 1'b1;
  logic gate = 1'b0;
  logic a = 1'b0;
  logic b = 1'b0;
  cbo_pkg::cbo_cfg_t cfg = '{cbo_pkg::MODE_FREQ, 2'h0, 1'b0, 1'b0};
  logic [3:0]  bcd;
  logic [7:0]  digit, dpm;
  logic        dp, meas_n, st, cl, bosc, osc, st_q, osc_q, bosc_q;
  logic [31:0] vals;
  int          ord_err, bad, lag, slot, n, s;
  int          n_store = 0;
  int          ro = 0;
  int          rb = 0;
  int          mismatches = 0;
  int          n_checks = 0;

  always #2 i_clk = ~i_clk;

  cbo_top #(.P_REF_DIV_10M(RDIV), .P_REF_DIV_1M(10), .P_MUX_DIV_10M(MUX),
    .P_IDLE_10M(ID10), .P_IDLE_1M(ID1), .P_IA_UPDATE_CYC(IAU)) i_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_clear_n(clear_n),
    .i_external_gate_in(gate), .i_in_a(a), .i_in_b(b), .i_osc_in(osc),
    .i_cfg(cfg), .o_bcd(bcd), .o_digit(digit), .o_dp(dp),
    .o_measuring_n(meas_n), .o_store_strobe(st), .o_clear_strobe(cl),
    .o_buf_osc(bosc));

  cbo_far_end i_far (
    .i_clk(i_clk), .i_bcd(bcd), .i_digit(digit), .i_dp(dp), .o_osc(osc),
    .o_vals(vals), .o_dp_mask(dpm), .o_order_err(ord_err), .o_bad(bad),
    .o_lag(lag), .o_slot(slot));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask

  task automatic wait_lvl(input logic v);
    int w;
    w = 0;
    while (meas_n !== v && w < 5000) begin
      tick(1);
      w++;
    end
  endtask

  // Length of the next idle interval, in clock cycles
  task automatic gap(output int c);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    c = 0;
    while (meas_n === 1'b1 && c < 5000) begin
      tick(1);
      c++;
    end
  endtask

  task automatic pulse_a(input int c);
    repeat (c) begin
      a = 1'b1;
      tick(3);
      a = 1'b0;
      tick(3);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // Strobe order and oscillator copy monitor
  always @(posedge i_clk) begin
    if (st_q) begin
      check(cl, 1'b1);
      check(meas_n, 1'b1);
    end
    st_q <= st;
    osc_q <= osc;
    bosc_q <= bosc;
    if (st === 1'b1)
      n_store++;
    if (osc && !osc_q)
      ro++;
    if (bosc && !bosc_q)
      rb++;
  end

  // Whole run is about 72k cycles
  initial begin
    #360000;
    mismatches++;
    test_done();
  end

  // ==========================================================================
  // Tests
  initial begin
    tick(3);
    check(meas_n, 1'b1);
    check(digit, 8'h00);
    tick(3);
    i_srst = 1'b0;
    tick(4);
    s = rb;
    n = ro - rb;
    tick(1000);
    n = ro - rb - n;
    check(rb - s >= 190 && n * n <= 1, 1'b1);
    gap(n);
    check(n >= ID10 * 5 && n <= ID10 * 5 + 12, 1'b1);
    cfg.mhz1 = 1'b1;
    gap(n);
    gap(n);
    check(n >= ID1 * 5 && n <= ID1 * 5 + 12, 1'b1);
    wait_lvl(1'b1);
    cfg.mhz1 = 1'b0;
    cfg.ext_en = 1'b1;
    wait_lvl(1'b0);
    s = n_store;
    tick(1000);
    gate = 1'b1;
    tick(1000);
    check(n_store == s, 1'b1);
    check(meas_n, 1'b0);
    gate = 1'b0;
    n = 0;
    while (n_store == s && n < 300) begin
      tick(1);
      n++;
    end
    check(n_store == s + 1 && n <= 2 * RDIV * 5 + 10, 1'b1);
    wait_lvl(1'b1);
    cfg = '{cbo_pkg::MODE_INTERVAL, 2'h0, 1'b0, 1'b0};
    wait_lvl(1'b0);
    a = 1'b1;
    b = 1'b1;
    tick(8);
    a = 1'b0;
    tick(8);
    b = 1'b0;
    tick(8);
    a = 1'b1;
    b = 1'b1;
    tick(8);
    s = n_store;
    a = 1'b0;
    tick(40);
    b = 1'b0;
    gap(n);
    check(n >= IAU && n <= IAU + 12, 1'b1);
    // A further A-then-B fall only primes again and must not measure
    a = 1'b1;
    b = 1'b1;
    tick(8);
    a = 1'b0;
    tick(8);
    b = 1'b0;
    tick(300);
    check(n_store == s + 1, 1'b1);
    cfg = '{cbo_pkg::MODE_UNIT, 2'h0, 1'b0, 1'b0};
    clear_n = 1'b0;
    pulse_a(30);
    tick(19300);
    check(vals, 32'h0);
    clear_n = 1'b1;
    tick(4);
    pulse_a(1290);
    tick(19300);
    check(vals, 32'h00001290);
    check(dpm, 8'h01);
    check(ord_err, 0);
    check(bad, 0);
    check(lag >= 500 && lag <= 1500, 1'b1);
    check(slot >= MUX * 5 / 8 - 5 && slot <= MUX * 5 / 8 + 5, 1'b1);
    // Short gate on B in ratio mode: 3 A rises per B period, 10 periods
    cfg = '{cbo_pkg::MODE_RATIO, 2'h1, 1'b0, 1'b0};
    tick(4);
    b = 1'b1;
    tick(6);
    repeat (10) begin
      b = 1'b0;
      pulse_a(3);
      b = 1'b1;
      tick(6);
    end
    tick(19300);
    check(vals, 32'h00000030);
    check(dpm, 8'h02);
    test_done();
  end
endmodule // counter_sequencing_and_bcd_output_bench

`default_nettype wire
